// >>> core/crf_pkg.sv
/*
 package of the register file and flag block: sizes, flag positions,
 operand sizes, flag-op codes and the structs that carry requests.
 assumes nothing beyond a SystemVerilog compiler.
*/
package crf_pkg;
	localparam int GP_COUNT  = 8;
	localparam int GP_WIDTH  = 32;
	localparam int SEL_WIDTH = 3;
	localparam int IP_WIDTH  = 24;
	localparam int FL_WIDTH  = 8;
	localparam logic [SEL_WIDTH-1:0] STACK_SEL = 3'h7;
	localparam int FL_MASK  = 7;
	localparam int FL_UIM   = 6;
	localparam int FL_HALF  = 5;
	localparam int FL_USER  = 4;
	localparam int FL_NEG   = 3;
	localparam int FL_ZERO  = 2;
	localparam int FL_OVF   = 1;
	localparam int FL_CARRY = 0;
	localparam int HC_BYTE  = 4;
	localparam int HC_WORD  = 12;
	localparam int HC_LONG  = 28;
	localparam int BCD_W    = 4;
	localparam logic [7:0] FLAGS_RST = 8'h80;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_WORD = 2'h1,
		SZ_LONG = 2'h2
	} crf_size_e;

	// which part of a wide_gp_reg an access touches
	typedef enum logic [1:0] {
		PT_LONG  = 2'h0,
		PT_EXT   = 2'h1,
		PT_UPPER = 2'h2,
		PT_LOWER = 2'h3
	} crf_part_e;

	typedef enum logic [2:0] {
		FO_NONE  = 3'h0,
		FO_LOAD  = 3'h1,
		FO_AND   = 3'h2,
		FO_OR    = 3'h3,
		FO_XOR   = 3'h4
	} crf_flop_e;

	typedef enum logic [2:0] {
		AO_NONE  = 3'h0,
		AO_ADD   = 3'h1,
		AO_SUB   = 3'h2,
		AO_LOGIC = 3'h3,
		AO_SHIFT = 3'h4
	} crf_alu_e;

	typedef struct packed {
		logic                 en;
		logic [SEL_WIDTH-1:0] sel;
		crf_part_e            part;
		logic [31:0]          data;
	} crf_wr_s;

	typedef struct packed {
		crf_alu_e    op;
		crf_size_e   size;
		logic        use_x;
		logic [31:0] a;
		logic [31:0] b;
		logic        shift_out;
		logic        ovf_in;
	} crf_alu_s;
endpackage

// >>> core/crf_gpr_bank.sv
/*
 bank of eight 32-bit general registers with long, extended-half,
 upper-byte and lower-byte write lanes and two combinational read ports.
 assumes one write request per cycle from the datapath on the same clock.
*/
`timescale 1ns/1ps
module crf_gpr_bank
	import crf_pkg::*;
#(
	parameter int N = GP_COUNT
) (
	input  wire logic                 clk,
	input  wire crf_wr_s              wr,
	input  wire logic [SEL_WIDTH-1:0] ra_sel,
	input  wire logic [SEL_WIDTH-1:0] rb_sel,
	output logic      [31:0]          ra_data,
	output logic      [31:0]          rb_data
);
	if (N != GP_COUNT) begin : g_bad_n
		$error("crf_gpr_bank: only eight registers");
	end

	// contents stay undefined after reset, so no reset on the array
	logic [31:0] regs [N];

	// per-byte write enable for a part
	function automatic logic [3:0] lane_mask(crf_part_e p);
		case (p)
			PT_LONG:  lane_mask = 4'hf;
			PT_EXT:   lane_mask = 4'hc;
			PT_UPPER: lane_mask = 4'h2;
			PT_LOWER: lane_mask = 4'h1;
			default:  lane_mask = 4'h0;
		endcase
	endfunction

	// narrow data arrives in the low bits; move it to its lane
	function automatic logic [31:0] lane_data(crf_part_e p, logic [31:0] d);
		case (p)
			PT_EXT:   lane_data = {d[15:0], 16'h0000};
			PT_UPPER: lane_data = {16'h0000, d[7:0], 8'h00};
			default:  lane_data = d;
		endcase
	endfunction

	logic [3:0]  wmask;
	logic [31:0] wdata;
	assign wmask = lane_mask(wr.part);
	assign wdata = lane_data(wr.part, wr.data);

	for (genvar g = 0; g < N; g++) begin : g_reg
		for (genvar b = 0; b < 4; b++) begin : g_lane
			always_ff @(posedge clk) begin
				if (wr.en && wr.sel == SEL_WIDTH'(g) && wmask[b]) begin
					regs[g][b*8 +: 8] <= wdata[b*8 +: 8];
				end
			end
		end
	end

	assign ra_data = regs[ra_sel];
	assign rb_data = regs[rb_sel];

	a_part_keep: assert property (@(posedge clk)
		wr.en && wr.part == PT_LOWER |=>
		regs[$past(wr.sel)][31:8] == $past(regs[wr.sel][31:8]))
		else $error("byte write disturbed other bits");
endmodule

// >>> core/crf_flag_alu.sv
/*
 flag generator: computes result, negative, zero, overflow and carry for
 add, subtract, logic and shift results of any size; half-carry for add and subtract.
 assumes operands arrive in the low bits, sign in the size's top bit.
*/
`timescale 1ns/1ps
module crf_flag_alu
	import crf_pkg::*;
(
	input  wire crf_alu_s    req,
	input  wire logic        carry_in,
	output logic [31:0]      result,
	output logic [5:0]       flags
);
	function automatic int top_bit(crf_size_e s);
		case (s)
			SZ_BYTE: top_bit = 7;
			SZ_WORD: top_bit = 15;
			default: top_bit = 31;
		endcase
	endfunction

	function automatic int half_bit(crf_size_e s);
		case (s)
			SZ_BYTE: half_bit = HC_BYTE;
			SZ_WORD: half_bit = HC_WORD;
			default: half_bit = HC_LONG;
		endcase
	endfunction

	// flags: {half, neg, zero, ovf, carry, valid-half}
	always_comb begin
		logic [32:0] sum;
		logic [32:0] hsum;
		logic [31:0] bb;
		logic [31:0] zmask;
		logic [31:0] hmask;
		logic        cin;
		logic        sa;
		logic        sb;
		logic        sr;
		int          t;
		int          h;
		sum   = '0;
		hsum  = '0;
		sa    = 1'b0;
		sb    = 1'b0;
		sr    = 1'b0;
		t     = top_bit(req.size);
		h     = half_bit(req.size);
		cin   = req.use_x & carry_in;
		bb    = (req.op == AO_SUB) ? ~req.b : req.b;
		// the 33-bit shift keeps the long mask exact; the cast drops bit 32
		zmask = 32'((33'h1 << (t + 1)) - 33'h1);
		hmask = 32'((33'h1 << h) - 33'h1);
		result = req.a;
		flags  = '0;
		if (req.op == AO_ADD || req.op == AO_SUB) begin
			if (req.op == AO_SUB) begin
				cin = ~cin;
			end
			sum    = {1'b0, req.a & zmask} + {1'b0, bb & zmask} + {32'h0, cin};
			hsum   = {1'b0, req.a & hmask} + {1'b0, bb & hmask}
			       + {32'h0, cin};
			result = sum[31:0] & zmask;
			sa = req.a[t];
			sb = bb[t];
			sr = result[t];
			// half-carry from the size's nibble boundary; borrow is inverse
			flags[5] = hsum[h] ^ (req.op == AO_SUB);
			flags[2] = (sa == sb) && (sr != sa);
			flags[1] = sum[t+1] ^ (req.op == AO_SUB);
		end else if (req.op == AO_SHIFT) begin
			flags[1] = req.shift_out;
			flags[2] = req.ovf_in;
		end
		flags[4] = result[t];
		flags[3] = (result & zmask) == 32'h0;
		flags[0] = (req.op == AO_ADD || req.op == AO_SUB);
	end
endmodule

// >>> core/crf_core_regs.sv
/*
 cpu register file and condition flags: eight general registers, the
 instruction pointer and condition_flags with flag update, flag ops,
 exception entry and branch condition evaluation.
 assumes the instruction datapath on the same clock issues requests.
*/
// Contract
// - eight identical 32-bit registers, usable as data or address
// - each splits into extended and lower 16-bit halves
// - each lower half splits into upper and lower bytes
// - register seven doubles as the stack top for calls and exceptions
// - 24-bit instruction pointer; bit zero reads as zero on fetch
// - mask bit 7 blocks all interrupts except the non-maskable one
// - exception entry sets the mask bit
// - bit 6 is a user bit or second interrupt mask
// - byte arithmetic: half-carry from bit 3
// - word arithmetic: half-carry from bit 11
// - long arithmetic: half-carry from bit 27
// - load, store, and, or, xor flag ops reach all flag bits
// - negative flag takes the result's sign bit
// - zero flag set on zero result, cleared otherwise
// - overflow flag set on overflow, cleared otherwise
// - carry holds carry, borrow, shifted bit, or bit accumulator
// - branches use sign, zero, overflow, carry; others leave flags
// - reset loads pointer from vector, sets mask; rest undefined
// - bit ops pick bit 0..7 of a byte; decimal adjust uses nibbles
// - odd word, long or fetch address loses its low bit
`timescale 1ns/1ps
module crf_core_regs
	import crf_pkg::*;
#(
	parameter int IPW = IP_WIDTH
) (
	input  wire logic                 REF_CLK,
	input  wire logic                 RST,
	input  wire logic [IPW-1:0]       RESET_VECTOR,
	input  wire crf_wr_s              GP_WR,
	input  wire logic [SEL_WIDTH-1:0] RA_SEL,
	input  wire logic [SEL_WIDTH-1:0] RB_SEL,
	input  wire logic                 IP_LOAD,
	input  wire logic [IPW-1:0]       IP_VALUE,
	input  wire logic                 IP_STEP,
	input  wire crf_alu_s             ALU_REQ,
	input  wire crf_flop_e            FLAG_OP,
	input  wire logic [7:0]           FLAG_OPND,
	input  wire logic                 BIT_WRITE,
	input  wire logic                 BIT_VALUE,
	input  wire logic [3:0]           BRANCH_COND,
	input  wire logic                 EXC_ENTRY,
	input  wire logic                 IRQ_PEND,
	input  wire logic                 NMI_PEND,
	input  wire logic [IPW-1:0]       DATA_ADDR,
	input  wire crf_size_e            DATA_SIZE,
	input  wire logic                 BIT_SEL_EN,
	input  wire logic [2:0]           BIT_SEL,
	input  wire logic [7:0]           BIT_BYTE,
	output logic      [31:0]          RA_DATA,
	output logic      [31:0]          RB_DATA,
	output logic      [31:0]          STACK_TOP,
	output logic      [31:0]          ALU_RESULT,
	output logic      [FL_WIDTH-1:0]  FLAGS,
	output logic      [IPW-1:0]       FETCH_ADDR,
	output logic      [IPW-1:0]       ACCESS_ADDR,
	output logic                      BRANCH_TAKEN,
	output logic                      IRQ_ACCEPT,
	output logic                      BIT_PICKED,
	output logic      [7:0]           BCD_DIGITS,
	output logic                      BOOT_DONE
);
	if (IPW != IP_WIDTH) begin : g_bad_ipw
		$error("crf_core_regs: pointer must be 24 bits");
	end

	typedef enum logic [2:0] {
		ST_RESET = 3'h1,
		ST_VECT  = 3'h2,
		ST_RUN   = 3'h4
	} crf_state_e;

	crf_state_e  state_q;
	crf_state_e  state_d;
	logic [IPW-1:0]      ip_q;
	logic [FL_WIDTH-1:0] fl_q;
	logic [FL_WIDTH-1:0] fl_d;
	logic [31:0] ra;
	logic [31:0] rb;
	logic [31:0] alu_res;
	logic [5:0]  alu_fl;

	crf_gpr_bank #(
		.N (GP_COUNT)
	) u_bank (
		.clk     (REF_CLK),
		.wr      (GP_WR),
		.ra_sel  (RA_SEL),
		.rb_sel  (RB_SEL),
		.ra_data (ra),
		.rb_data (rb)
	);

	crf_flag_alu u_alu (
		.req      (ALU_REQ),
		.carry_in (fl_q[FL_CARRY]),
		.result   (alu_res),
		.flags    (alu_fl)
	);

	// stack top is register seven read by a third, fixed port
	logic [31:0] stack_w;
	assign stack_w = u_bank.regs[STACK_SEL];

	// a short boot sequence stands in for the vector fetch
	always_comb begin
		case (state_q)
			ST_RESET: state_d = ST_VECT;
			ST_VECT:  state_d = ST_RUN;
			ST_RUN:   state_d = ST_RUN;
			default:  state_d = ST_RESET;
		endcase
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			state_q <= ST_RESET;
		end else begin
			state_q <= state_d;
		end
	end

	// pointer: the vector is a port, so it is taken after release
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			ip_q <= '0;
		end else if (state_q == ST_VECT) begin
			ip_q <= RESET_VECTOR;
		end else if (state_q == ST_RUN && IP_LOAD) begin
			ip_q <= IP_VALUE;
		end else if (state_q == ST_RUN && IP_STEP) begin
			ip_q <= ip_q + IPW'(2);
		end
	end

	// flag next value: flag ops, then arithmetic, then bit accumulator
	always_comb begin
		fl_d = fl_q;
		case (FLAG_OP)
			FO_LOAD: fl_d = FLAG_OPND;
			FO_AND:  fl_d = fl_q & FLAG_OPND;
			FO_OR:   fl_d = fl_q | FLAG_OPND;
			FO_XOR:  fl_d = fl_q ^ FLAG_OPND;
			default: begin
				// ops that do not touch a flag leave it as it was
				if (ALU_REQ.op != AO_NONE) begin
					if (alu_fl[0]) begin
						fl_d[FL_HALF] = alu_fl[5];
					end
					fl_d[FL_NEG]   = alu_fl[4];
					fl_d[FL_ZERO]  = alu_fl[3];
					fl_d[FL_OVF]   = alu_fl[2];
					fl_d[FL_CARRY] = alu_fl[1];
				end else if (BIT_WRITE) begin
					fl_d[FL_CARRY] = BIT_VALUE;
				end
			end
		endcase
		// exception entry wins so a stale load cannot unmask
		if (EXC_ENTRY) begin
			fl_d[FL_MASK] = 1'b1;
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			fl_q <= FLAGS_RST;
		end else if (state_q == ST_RUN) begin
			fl_q <= fl_d;
		end
	end

	// branch condition code: four bits in the usual cc order
	function automatic logic cond_true(logic [3:0] cc, logic [7:0] f);
		logic n;
		logic z;
		logic v;
		logic c;
		n = f[FL_NEG];
		z = f[FL_ZERO];
		v = f[FL_OVF];
		c = f[FL_CARRY];
		case (cc)
			4'h0: cond_true = 1'b1;
			4'h1: cond_true = 1'b0;
			4'h2: cond_true = ~(c | z);
			4'h3: cond_true = c | z;
			4'h4: cond_true = ~c;
			4'h5: cond_true = c;
			4'h6: cond_true = ~z;
			4'h7: cond_true = z;
			4'h8: cond_true = ~v;
			4'h9: cond_true = v;
			4'ha: cond_true = ~n;
			4'hb: cond_true = n;
			4'hc: cond_true = ~(n ^ v);
			4'hd: cond_true = n ^ v;
			4'he: cond_true = ~(z | (n ^ v));
			default: cond_true = z | (n ^ v);
		endcase
	endfunction

	function automatic logic [IPW-1:0] even_addr(logic [IPW-1:0] a);
		even_addr = {a[IPW-1:1], 1'b0};
	endfunction

	// all outputs registered; most trail their inputs by one cycle, FLAGS and FETCH_ADDR by two
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			RA_DATA      <= '0;
			RB_DATA      <= '0;
			STACK_TOP    <= '0;
			ALU_RESULT   <= '0;
			BRANCH_TAKEN <= 1'b0;
			BIT_PICKED   <= 1'b0;
			BCD_DIGITS   <= '0;
		end else begin
			RA_DATA      <= ra;
			RB_DATA      <= rb;
			STACK_TOP    <= stack_w;
			ALU_RESULT   <= alu_res;
			BRANCH_TAKEN <= cond_true(BRANCH_COND, fl_q);
			BIT_PICKED   <= BIT_SEL_EN & BIT_BYTE[BIT_SEL];
			BCD_DIGITS   <= {BIT_BYTE[7:BCD_W], BIT_BYTE[BCD_W-1:0]};
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			FETCH_ADDR  <= '0;
			ACCESS_ADDR <= '0;
		end else begin
			FETCH_ADDR  <= even_addr(ip_q);
			// byte accesses keep the low bit; wider ones lose it
			ACCESS_ADDR <= (DATA_SIZE == SZ_BYTE) ? DATA_ADDR
			             : even_addr(DATA_ADDR);
		end
	end

	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			IRQ_ACCEPT <= 1'b0;
			FLAGS      <= FLAGS_RST;
			BOOT_DONE  <= 1'b0;
		end else begin
			IRQ_ACCEPT <= NMI_PEND | (IRQ_PEND & ~fl_q[FL_MASK]);
			FLAGS      <= fl_q;
			BOOT_DONE  <= (state_q == ST_RUN);
		end
	end

	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);

	sequence s_exc_seen;
		state_q == ST_RUN && EXC_ENTRY;
	endsequence

	a_exc_mask_set: assert property (s_exc_seen |=> fl_q[FL_MASK])
		else $error("mask not set on exception entry");
	a_nmi_always: assert property (NMI_PEND |=> IRQ_ACCEPT)
		else $error("nmi not accepted");
	a_irq_masked: assert property (
		fl_q[FL_MASK] && !NMI_PEND |=> !IRQ_ACCEPT)
		else $error("interrupt passed the mask");
	a_fetch_even: assert property (FETCH_ADDR[0] == 1'b0)
		else $error("fetch address odd");
	a_access_align: assert property (
		DATA_SIZE != SZ_BYTE |=> ACCESS_ADDR == even_addr($past(DATA_ADDR)))
		else $error("wide access not aligned down");
	a_flags_hold: assert property (
		state_q == ST_RUN && FLAG_OP == FO_NONE && ALU_REQ.op == AO_NONE
		&& !BIT_WRITE && !EXC_ENTRY |=> $stable(fl_q))
		else $error("flags changed without cause");
	a_zero_flag: assert property (
		state_q == ST_RUN && FLAG_OP == FO_NONE && ALU_REQ.op == AO_ADD
		&& alu_fl[3] |=> fl_q[FL_ZERO])
		else $error("zero flag not set");
	a_flag_load: assert property (
		state_q == ST_RUN && FLAG_OP == FO_LOAD && !EXC_ENTRY
		|=> fl_q == $past(FLAG_OPND))
		else $error("flag load lost");
	a_vector_load: assert property (
		state_q == ST_VECT |=> ip_q == $past(RESET_VECTOR))
		else $error("vector not loaded");
	a_bit_pick: assert property (
		BIT_SEL_EN |=> BIT_PICKED == $past(BIT_BYTE[BIT_SEL]))
		else $error("wrong bit picked");
	a_reset_mask: assert property (
		state_q == ST_RESET |-> fl_q[FL_MASK])
		else $error("mask clear after reset");
endmodule

// >>> verif/crf_tb.sv
/*
 self-checking bench of the register file and flag block: drives every
 port of crf_core_regs directly and compares against hand-worked values.
 assumes the core package and modules are compiled before this file.
*/
`timescale 1ns/1ps
module testbench;
	import crf_pkg::*;

	logic        ref_clk;
	logic        rst;
	logic [23:0] reset_vector;
	crf_wr_s     gp_wr;
	logic [2:0]  ra_sel;
	logic [2:0]  rb_sel;
	logic        ip_load;
	logic [23:0] ip_value;
	logic        ip_step;
	crf_alu_s    alu_req;
	crf_flop_e   flag_op;
	logic [7:0]  flag_opnd;
	logic        bit_write;
	logic        bit_value;
	logic [3:0]  branch_cond;
	logic        exc_entry;
	logic        irq_pend;
	logic        nmi_pend;
	logic [23:0] data_addr;
	crf_size_e   data_size;
	logic        bit_sel_en;
	logic [2:0]  bit_sel;
	logic [7:0]  bit_byte;
	logic [31:0] ra_data;
	logic [31:0] rb_data;
	logic [31:0] stack_top;
	logic [31:0] alu_result;
	logic [7:0]  flags;
	logic [23:0] fetch_addr;
	logic [23:0] access_addr;
	logic        branch_taken;
	logic        irq_accept;
	logic        bit_picked;
	logic [7:0]  bcd_digits;
	logic        boot_done;
	logic [31:0] v [8];
	int          bad_count;
	int          n_checks;

	crf_core_regs u_dut (
		.REF_CLK(ref_clk), .RST(rst), .RESET_VECTOR(reset_vector),
		.GP_WR(gp_wr), .RA_SEL(ra_sel), .RB_SEL(rb_sel),
		.IP_LOAD(ip_load), .IP_VALUE(ip_value), .IP_STEP(ip_step),
		.ALU_REQ(alu_req), .FLAG_OP(flag_op), .FLAG_OPND(flag_opnd),
		.BIT_WRITE(bit_write), .BIT_VALUE(bit_value),
		.BRANCH_COND(branch_cond), .EXC_ENTRY(exc_entry),
		.IRQ_PEND(irq_pend), .NMI_PEND(nmi_pend), .DATA_ADDR(data_addr),
		.DATA_SIZE(data_size), .BIT_SEL_EN(bit_sel_en),
		.BIT_SEL(bit_sel), .BIT_BYTE(bit_byte), .RA_DATA(ra_data),
		.RB_DATA(rb_data), .STACK_TOP(stack_top),
		.ALU_RESULT(alu_result), .FLAGS(flags), .FETCH_ADDR(fetch_addr),
		.ACCESS_ADDR(access_addr), .BRANCH_TAKEN(branch_taken),
		.IRQ_ACCEPT(irq_accept), .BIT_PICKED(bit_picked),
		.BCD_DIGITS(bcd_digits), .BOOT_DONE(boot_done)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// inputs always move 1 ns after the edge so no race with the design
	task step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR t=%0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task tally_and_finish;
		$display("checks %0d errors %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// caller lowers en after the last write of a burst
	task gw(input int s, input crf_part_e p, input logic [31:0] d);
		gp_wr.en = 1'b1;
		gp_wr.sel = s[2:0];
		gp_wr.part = p;
		gp_wr.data = d;
		step(1);
	endtask

	task fop(input crf_flop_e op, input logic [7:0] val);
		flag_op = op;
		flag_opnd = val;
		step(1);
		flag_op = FO_NONE;
		step(1);
	endtask

	task alu(input crf_alu_e op, input crf_size_e sz, input logic [31:0] a,
		input logic [31:0] b, input logic [31:0] er, input logic [7:0] ef);
		logic [31:0] m;
		m = (sz == SZ_BYTE) ? 32'hff : (sz == SZ_WORD) ? 32'hffff : '1;
		alu_req = '{op: op, size: sz, use_x: 1'b0, a: a, b: b,
			shift_out: 1'b0, ovf_in: 1'b0};
		step(1);
		chk(alu_result & m, er);
		alu_req.op = AO_NONE;
		step(1);
		chk({24'h0, flags}, {24'h0, ef});
	endtask

	function automatic logic bexp(input int c, input logic [7:0] f);
		logic n, z, o, k;
		n = f[3];
		z = f[2];
		o = f[1];
		k = f[0];
		case (c)
			0: return 1'b1;
			1: return 1'b0;
			2: return !(k | z);
			3: return k | z;
			4: return !k;
			5: return k;
			6: return !z;
			7: return z;
			8: return !o;
			9: return o;
			10: return !n;
			11: return n;
			12: return !(n ^ o);
			13: return n ^ o;
			14: return !z && !(n ^ o);
			default: return z | (n ^ o);
		endcase
	endfunction

	task br(input logic [7:0] f);
		fop(FO_LOAD, f);
		for (int c = 0; c < 16; c++) begin
			branch_cond = c[3:0];
			step(1);
			chk(branch_taken, bexp(c, f));
		end
	endtask

	initial begin
		repeat (5000) @(posedge ref_clk);
		bad_count++;
		tally_and_finish();
	end

	initial begin
		bad_count = 0;
		n_checks = 0;
		rst = 1'b1;
		reset_vector = 24'h012345;
		gp_wr = '0;
		ra_sel = 3'h0;
		rb_sel = 3'h0;
		ip_load = 1'b0;
		ip_value = 24'h0;
		ip_step = 1'b0;
		alu_req = '0;
		flag_op = FO_NONE;
		flag_opnd = 8'h00;
		bit_write = 1'b0;
		bit_value = 1'b0;
		branch_cond = 4'h0;
		exc_entry = 1'b0;
		irq_pend = 1'b0;
		nmi_pend = 1'b0;
		data_addr = 24'h0;
		data_size = SZ_BYTE;
		bit_sel_en = 1'b0;
		bit_sel = 3'h0;
		bit_byte = 8'h00;
		step(5);
		chk(flags, 8'h80);
		chk(boot_done, 1'b0);
		// a flag load during boot must be ignored
		flag_op = FO_LOAD;
		rst = 1'b0;
		step(2);
		flag_op = FO_NONE;
		step(2);
		chk(flags, 8'h80);
		chk(boot_done, 1'b1);
		chk(fetch_addr, 24'h012344);
		for (int i = 0; i < 8; i++) begin
			v[i] = {4{i[7:0]}} ^ 32'ha5c3_0f00;
			gw(i, PT_LONG, v[i]);
		end
		gw(3, PT_EXT, 32'h5555_beef);
		gw(4, PT_UPPER, 32'hcccc_cc12);
		gw(5, PT_LOWER, 32'hcccc_cc34);
		gp_wr.en = 1'b0;
		v[3] = {16'hbeef, v[3][15:0]};
		v[4] = {v[4][31:16], 8'h12, v[4][7:0]};
		v[5] = {v[5][31:8], 8'h34};
		for (int i = 0; i < 8; i++) begin
			ra_sel = i[2:0];
			rb_sel = 3'h7 - i[2:0];
			step(1);
			chk(ra_data, v[i]);
			chk(rb_data, v[7-i]);
		end
		chk(stack_top, v[7]);
		fop(FO_LOAD, 8'h00);
		alu(AO_ADD, SZ_BYTE, 32'h08, 32'h08, 32'h10, 8'h20);
		alu(AO_ADD, SZ_BYTE, 32'h7f, 32'h01, 32'h80, 8'h2a);
		alu(AO_ADD, SZ_BYTE, 32'hff, 32'h01, 32'h00, 8'h25);
		alu(AO_SUB, SZ_BYTE, 32'h00, 32'h01, 32'hff, 8'h29);
		alu(AO_ADD, SZ_WORD, 32'h0800, 32'h0800, 32'h1000, 8'h20);
		alu(AO_ADD, SZ_WORD, 32'h0008, 32'h0008, 32'h0010, 8'h00);
		alu(AO_ADD, SZ_LONG, 32'h0800_0000, 32'h0800_0000,
			32'h1000_0000, 8'h20);
		alu(AO_ADD, SZ_LONG, 32'h0800, 32'h0800, 32'h1000, 8'h00);
		alu(AO_SUB, SZ_LONG, 32'h8000_0000, 32'h1,
			32'h7fff_ffff, 8'h22);
		alu(AO_SUB, SZ_WORD, 32'h5, 32'h5, 32'h0, 8'h04);
		alu_req.op = AO_SHIFT;
		alu_req.shift_out = 1'b1;
		alu_req.ovf_in = 1'b1;
		step(1);
		alu_req.op = AO_NONE;
		step(1);
		chk(flags[1:0], 2'h3);
		alu(AO_LOGIC, SZ_BYTE, 32'h0, 32'h0, 32'h0, 8'h04);
		bit_write = 1'b1;
		bit_value = 1'b1;
		step(1);
		bit_write = 1'b0;
		step(1);
		chk(flags, 8'h05);
		// add with extend takes the carry left by the bit store
		alu_req = '{op: AO_ADD, size: SZ_BYTE, use_x: 1'b1, a: 32'h0e,
			b: 32'h01, shift_out: 1'b0, ovf_in: 1'b0};
		step(1);
		chk(alu_result, 32'h10);
		alu_req.op = AO_NONE;
		step(1);
		chk(flags, 8'h20);
		// entry and a flag load in one cycle: entry keeps the mask set
		flag_op = FO_LOAD;
		exc_entry = 1'b1;
		step(1);
		flag_op = FO_NONE;
		exc_entry = 1'b0;
		step(1);
		chk(flags, 8'h80);
		irq_pend = 1'b1;
		step(1);
		chk(irq_accept, 1'b0);
		nmi_pend = 1'b1;
		step(1);
		chk(irq_accept, 1'b1);
		nmi_pend = 1'b0;
		fop(FO_AND, 8'h7f);
		chk(irq_accept, 1'b1);
		fop(FO_OR, 8'h50);
		chk(flags, 8'h50);
		fop(FO_XOR, 8'h70);
		chk(flags, 8'h20);
		fop(FO_AND, 8'h2f);
		chk(flags, 8'h20);
		fop(FO_LOAD, 8'hff);
		chk(flags, 8'hff);
		irq_pend = 1'b0;
		br(8'h0a);
		br(8'h05);
		data_addr = 24'h000101;
		step(1);
		chk(access_addr, 24'h000101);
		data_size = SZ_WORD;
		step(1);
		chk(access_addr, 24'h000100);
		data_size = SZ_LONG;
		step(1);
		chk(access_addr, 24'h000100);
		ip_load = 1'b1;
		ip_value = 24'h000201;
		step(1);
		ip_load = 1'b0;
		step(1);
		chk(fetch_addr, 24'h000200);
		ip_step = 1'b1;
		step(1);
		ip_step = 1'b0;
		step(1);
		chk(fetch_addr, 24'h000202);
		bit_sel_en = 1'b1;
		bit_byte = 8'ha5;
		for (int i = 0; i < 8; i++) begin
			bit_sel = i[2:0];
			step(1);
			chk(bit_picked, bit_byte[i]);
		end
		chk(bcd_digits, 8'ha5);
		tally_and_finish();
	end
endmodule
